// file: rtl/rqfc_map.vh
// How it works
// - monitor failure starts disqualify timer; disqualified when delay elapses
// - disqualify code: 00 minimum, 01 10 ms, 10 50 ms, 11 2.5 s
// - qualify timer starts once both monitors clear; qualified on expiry
// - qualify code multiplies disqualify delay by 2, 4, 6 or 8
// - qualify register resets to four times for every reference
// - writing one to freeze register stops sticky status updates
// - writing zero resumes updates; freeze register resets to zero
// - base rate register is unsigned hertz, 16 bits
// - wide registers big endian: high byte at lower address
// - base rate resets to the 40 kHz code
// - multiplier resets to 3888
// - timer failure shown in bit 3 of each four-bit failure group
`ifndef RQFC_MAP_VH
`define RQFC_MAP_VH
`define RQFC_ADDR_DISQ      7'h0b
`define RQFC_ADDR_QUAL      7'h0c
`define RQFC_ADDR_FREEZE    7'h0d
`define RQFC_ADDR_BASE_HI   7'h10
`define RQFC_ADDR_BASE_LO   7'h11
`define RQFC_ADDR_MULT_HI   7'h12
`define RQFC_ADDR_MULT_LO   7'h13
`define RQFC_RST_DISQ       8'haa
`define RQFC_RST_QUAL       8'h55
`define RQFC_RST_FREEZE     8'h00
`define RQFC_RST_BASE       16'h9c40
`define RQFC_RST_MULT       16'h0f30
`define RQFC_FREEZE_ON      8'h01
`define RQFC_FREEZE_OFF     8'h00
`define RQFC_FAIL_SOAK_BIT  3
`define RQFC_MIN_CYC        32'h0000_0001
`define RQFC_CLK_HZ         40000000
`define RQFC_T10_MS         10
`define RQFC_T50_MS         50
`define RQFC_T2500_MS       2500
`define RQFC_CYC(ms)        ((`RQFC_CLK_HZ / 1000) * (ms))
`endif

// file: rtl/rqfc_soak_timer.v
`timescale 1ns/1ps
`include "rqfc_map.vh"
// one reference: disqualify / qualify soak timing
module rqfc_soak_timer #(
  parameter [31:0] MIN_CYC  = `RQFC_MIN_CYC,     // minimum delay cycles
  parameter [31:0] D10_CYC  = `RQFC_CYC(`RQFC_T10_MS),
  parameter [31:0] D50_CYC  = `RQFC_CYC(`RQFC_T50_MS),
  parameter [31:0] D2500_CYC = `RQFC_CYC(`RQFC_T2500_MS)
) (
  input  wire       clock,       // system clock
  input  wire       rst_b,       // async reset, active low
  input  wire       monFail,     // synchronised monitor failure (coarse or single cycle)
  input  wire [1:0] disqSel,     // disqualify delay code
  input  wire [1:0] qualSel,     // qualify multiple code
  output wire       disqualified // soak result, high = failed
);
  reg  [35:0] cnt_ff;
  reg         disq_ff;
  reg  [35:0] nxt_cnt;
  reg         nxt_disq;
  reg  [31:0] disqCyc;
  reg  [35:0] qualCyc;

  // ---------------------------------------------------------------
  // delay decode
  // ---------------------------------------------------------------
  always @* begin
    case (disqSel)
      2'h0:    disqCyc = MIN_CYC;
      2'h1:    disqCyc = D10_CYC;
      2'h2:    disqCyc = D50_CYC;
      default: disqCyc = D2500_CYC;
    endcase
    qualCyc = {4'h0, disqCyc} * {33'h0, qualSel, 1'b0} + {3'h0, disqCyc, 1'b0};
  end

  // ---------------------------------------------------------------
  // soak counter
  // ---------------------------------------------------------------
  always @* begin
    nxt_cnt  = cnt_ff;
    nxt_disq = disq_ff;
    if (!disq_ff) begin
      if (!monFail)
        nxt_cnt = 36'h0;
      else if (cnt_ff + 36'h1 >= {4'h0, disqCyc}) begin
        nxt_disq = 1'b1;
        nxt_cnt  = 36'h0;
      end else
        nxt_cnt = cnt_ff + 36'h1;
    end else begin
      if (monFail)
        nxt_cnt = 36'h0;
      else if (cnt_ff + 36'h1 >= qualCyc) begin
        nxt_disq = 1'b0;
        nxt_cnt  = 36'h0;
      end else
        nxt_cnt = cnt_ff + 36'h1;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff  <= 36'h0;
      disq_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      disq_ff <= nxt_disq;
    end
  end

  assign disqualified = disq_ff;
endmodule // rqfc_soak_timer

// file: rtl/rqfc_ref_qualify.v
`timescale 1ns/1ps
`include "rqfc_map.vh"
module rqfc_ref_qualify #(
  parameter        NREF      = 4,               // reference inputs
  parameter [31:0] MIN_CYC   = `RQFC_MIN_CYC,   // minimum delay cycles
  parameter [31:0] D10_CYC   = `RQFC_CYC(`RQFC_T10_MS),
  parameter [31:0] D50_CYC   = `RQFC_CYC(`RQFC_T50_MS),
  parameter [31:0] D2500_CYC = `RQFC_CYC(`RQFC_T2500_MS)
) (
  input  wire            clock,        // 40 MHz system clock
  input  wire            rst_b,        // async reset, active low
  input  wire            regWr,        // register write strobe
  input  wire            regRd,        // register read strobe
  input  wire [6:0]      regAddr,      // byte address
  input  wire [7:0]      regWdata,     // write byte
  output reg  [7:0]      regRdata_ff,  // read byte, one cycle after regRd
  input  wire [NREF-1:0] lossOfClock,  // loss_of_clock per ref (async)
  input  wire [NREF-1:0] singleCycMon, // single_cycle_monitor fail (async)
  input  wire [NREF-1:0] coarseFreqMon,// coarse_freq_monitor fail (async)
  output reg  [4*NREF-1:0] failGroup_ff, // {soak,coarse,single,loss} per ref
  output reg             statusFreeze_ff, // sticky status update hold
  output reg  [15:0]     baseRate_ff,  // reference 0 base rate, Hz
  output reg  [15:0]     rateMult_ff   // reference 0 multiplier
);
  reg  [7:0]        disqReg_ff;
  reg  [7:0]        qualReg_ff;
  reg  [7:0]        freezeReg_ff;
  reg  [3*NREF-1:0] sync1_ff;
  reg  [3*NREF-1:0] sync2_ff;
  wire [NREF-1:0]   soakFail;
  wire [4*NREF-1:0] nxt_failGroup;
  wire [6:0]        wrHit;
  wire [6:0]        rdHit;
  reg  [7:0]        nxt_disqReg;
  reg  [7:0]        nxt_qualReg;
  reg  [7:0]        nxt_freezeReg;
  reg  [7:0]        nxt_regRdata;
  reg  [15:0]       nxt_baseRate;
  reg  [15:0]       nxt_rateMult;
  reg               nxt_statusFreeze;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  localparam SEL_DISQ    = 0;
  localparam SEL_QUAL    = 1;
  localparam SEL_FREEZE  = 2;
  localparam SEL_BASE_HI = 3;
  localparam SEL_BASE_LO = 4;
  localparam SEL_MULT_HI = 5;
  localparam SEL_MULT_LO = 6;

  // one-hot register select, all zero for an unmapped byte address
  function [6:0] decodeAddr(input [6:0] addr);
    if (addr == `RQFC_ADDR_DISQ)
      decodeAddr = 7'h01;
    else if (addr == `RQFC_ADDR_QUAL)
      decodeAddr = 7'h02;
    else if (addr == `RQFC_ADDR_FREEZE)
      decodeAddr = 7'h04;
    else if (addr == `RQFC_ADDR_BASE_HI)
      decodeAddr = 7'h08;
    else if (addr == `RQFC_ADDR_BASE_LO)
      decodeAddr = 7'h10;
    else if (addr == `RQFC_ADDR_MULT_HI)
      decodeAddr = 7'h20;
    else if (addr == `RQFC_ADDR_MULT_LO)
      decodeAddr = 7'h40;
    else
      decodeAddr = 7'h00;
  endfunction

  // write and read share one decode, so the two maps cannot drift apart
  // strobes gate the hits; a stray address alone never selects anything
  assign wrHit = regWr ? decodeAddr(regAddr) : 7'h00;
  assign rdHit = regRd ? decodeAddr(regAddr) : 7'h00;

  // ---------------------------------------------------------------
  // monitor input synchronisers
  // ---------------------------------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff <= {3*NREF{1'b0}};
      sync2_ff <= {3*NREF{1'b0}};
    end else begin
      sync1_ff <= {coarseFreqMon, singleCycMon, lossOfClock};
      sync2_ff <= sync1_ff;
    end
  end

  // ---------------------------------------------------------------
  // per-reference soak timers and failure groups
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NREF; g = g + 1) begin : gRef
      rqfc_soak_timer #(
        .MIN_CYC   (MIN_CYC),
        .D10_CYC   (D10_CYC),
        .D50_CYC   (D50_CYC),
        .D2500_CYC (D2500_CYC)
      ) uTimer (
        .clock        (clock),
        .rst_b        (rst_b),
        .monFail      (sync2_ff[2*NREF+g] | sync2_ff[NREF+g]),
        .disqSel      (disqReg_ff[2*g+1:2*g]),
        .qualSel      (qualReg_ff[2*g+1:2*g]),
        .disqualified (soakFail[g])
      );
      assign nxt_failGroup[4*g+3:4*g] = {soakFail[g], sync2_ff[2*NREF+g],
                                         sync2_ff[NREF+g], sync2_ff[g]};
    end
  endgenerate

  // one register for all groups keeps a single driver per output
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b)
      failGroup_ff <= {4*NREF{1'b0}};
    else
      failGroup_ff <= nxt_failGroup;
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  // each byte lands at once: a host reading between the two bytes of a
  // wide register sees a mixed value, the price of having no staging
  always @* begin
    nxt_disqReg   = disqReg_ff;
    nxt_qualReg   = qualReg_ff;
    nxt_freezeReg = freezeReg_ff;
    nxt_baseRate  = baseRate_ff;
    nxt_rateMult  = rateMult_ff;
    if (wrHit[SEL_DISQ])
      nxt_disqReg = regWdata;
    if (wrHit[SEL_QUAL])
      nxt_qualReg = regWdata;
    // any byte is stored; only 0x00 and 0x01 move the freeze output
    if (wrHit[SEL_FREEZE])
      nxt_freezeReg = regWdata;
    if (wrHit[SEL_BASE_HI])
      nxt_baseRate[15:8] = regWdata;
    if (wrHit[SEL_BASE_LO])
      nxt_baseRate[7:0] = regWdata;
    if (wrHit[SEL_MULT_HI])
      nxt_rateMult[15:8] = regWdata;
    if (wrHit[SEL_MULT_LO])
      nxt_rateMult[7:0] = regWdata;
  end

  // ---------------------------------------------------------------
  // freeze control
  // ---------------------------------------------------------------
  // freeze on value one
  // resume on value zero
  // other values leave the previous freeze state standing
  always @* begin
    nxt_statusFreeze = statusFreeze_ff;
    if (wrHit[SEL_FREEZE]) begin
      if (regWdata == `RQFC_FREEZE_ON)
        nxt_statusFreeze = 1'b1;
      else if (regWdata == `RQFC_FREEZE_OFF)
        nxt_statusFreeze = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // read back unsigned bytes
  // unmapped bytes read zero so a probe never sees stale data
  always @* begin
    nxt_regRdata = regRdata_ff;
    if (regRd) begin
      if (rdHit[SEL_DISQ])
        nxt_regRdata = disqReg_ff;
      else if (rdHit[SEL_QUAL])
        nxt_regRdata = qualReg_ff;
      else if (rdHit[SEL_FREEZE])
        nxt_regRdata = freezeReg_ff;
      else if (rdHit[SEL_BASE_HI])
        nxt_regRdata = baseRate_ff[15:8];
      else if (rdHit[SEL_BASE_LO])
        nxt_regRdata = baseRate_ff[7:0];
      else if (rdHit[SEL_MULT_HI])
        nxt_regRdata = rateMult_ff[15:8];
      else if (rdHit[SEL_MULT_LO])
        nxt_regRdata = rateMult_ff[7:0];
      else
        nxt_regRdata = 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      disqReg_ff      <= `RQFC_RST_DISQ;
      qualReg_ff      <= `RQFC_RST_QUAL;
      freezeReg_ff    <= `RQFC_RST_FREEZE;
      statusFreeze_ff <= 1'b0;
      baseRate_ff     <= `RQFC_RST_BASE;
      rateMult_ff     <= `RQFC_RST_MULT;
      regRdata_ff     <= 8'h00;
    end else begin
      disqReg_ff      <= nxt_disqReg;
      qualReg_ff      <= nxt_qualReg;
      freezeReg_ff    <= nxt_freezeReg;
      statusFreeze_ff <= nxt_statusFreeze;
      baseRate_ff     <= nxt_baseRate;
      rateMult_ff     <= nxt_rateMult;
      regRdata_ff     <= nxt_regRdata;
    end
  end
endmodule // rqfc_ref_qualify

// file: tb/rqfc_checker_assertions.sv
`timescale 1ns/1ps
module rqfc_checker #(
  parameter NREF = 4
) (
  input wire              clock,           // system clock
  input wire              rst_b,           // async reset, active low
  input wire              regWr,           // write strobe
  input wire              regRd,           // read strobe
  input wire [6:0]        regAddr,         // byte address
  input wire [7:0]        regWdata,        // write byte
  input wire [7:0]        regRdata_ff,     // read byte
  input wire [NREF-1:0]   lossOfClock,     // loss of clock levels
  input wire [NREF-1:0]   singleCycMon,    // single cycle fail levels
  input wire [NREF-1:0]   coarseFreqMon,   // coarse freq fail levels
  input wire [4*NREF-1:0] failGroup_ff,    // failure groups
  input wire              statusFreeze_ff, // sticky update hold
  input wire [15:0]       baseRate_ff,     // base rate
  input wire [15:0]       rateMult_ff      // rate multiplier
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // run lengths of reference 0 monitor state, saturating
  reg  [7:0] failRun_ff;
  reg  [7:0] clearRun_ff;
  wire       mon0 = coarseFreqMon[0] | singleCycMon[0];
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      failRun_ff  <= 8'h00;
      clearRun_ff <= 8'h00;
    end else begin
      failRun_ff  <= mon0 ? failRun_ff + {7'h00, failRun_ff != 8'hff} : 8'h00;
      clearRun_ff <= mon0 ? 8'h00 : clearRun_ff + {7'h00, clearRun_ff != 8'hff};
    end
  end
  freeze_set_a: assert property (regWr && regAddr == 7'h0d &&
    regWdata == 8'h01 |=> statusFreeze_ff) else $error("freeze not set");
  freeze_clear_a: assert property (regWr && regAddr == 7'h0d &&
    regWdata == 8'h00 |=> !statusFreeze_ff) else $error("freeze not cleared");
  freeze_hold_a: assert property (!(regWr && regAddr == 7'h0d &&
    regWdata[7:1] == 7'h00) |=> $stable(statusFreeze_ff))
    else $error("freeze changed without command");
  base_high_a: assert property (regWr && regAddr == 7'h10
    |=> baseRate_ff[15:8] == $past(regWdata)) else $error("base high byte");
  base_low_a: assert property (regWr && regAddr == 7'h11
    |=> baseRate_ff[7:0] == $past(regWdata)) else $error("base low byte");
  mult_high_a: assert property (regWr && regAddr == 7'h12
    |=> rateMult_ff[15:8] == $past(regWdata)) else $error("mult high byte");
  mult_low_a: assert property (regWr && regAddr == 7'h13
    |=> rateMult_ff[7:0] == $past(regWdata)) else $error("mult low byte");
  read_base_a: assert property (regRd && regAddr == 7'h10
    |=> regRdata_ff == $past(baseRate_ff[15:8])) else $error("read base");
  soak_fail_a: assert property (failRun_ff >= 8'd24
    |-> failGroup_ff[3]) else $error("reference not disqualified");
  soak_clear_a: assert property (clearRun_ff >= 8'd140
    |-> !failGroup_ff[3]) else $error("reference not requalified");
  cover property ($rose(failGroup_ff[3]));
  cover property ($rose(statusFreeze_ff));
  cover property (regRd && regAddr == 7'h12);
endmodule // rqfc_checker

// file: tb/rqfc_host_model.sv
`timescale 1ns/1ps
module rqfc_host_model (
  input  wire       clock,       // system clock
  input  wire [7:0] regRdata_ff, // read byte from device
  output reg        regWr,       // write strobe
  output reg        regRd,       // read strobe
  output reg  [6:0] regAddr,     // byte address
  output reg  [7:0] regWdata     // write byte
);
  initial begin
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 7'h00;
    regWdata = 8'h00;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(negedge clock);
    regWr = 1'b1;
    regAddr = a;
    regWdata = v;
    @(negedge clock);
    regWr = 1'b0;
    regWdata = ~v;
  endtask
  task automatic wr16(input logic [6:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 7'h01, v[7:0]);
  endtask
  // halved input: rate times multiplier gives half the frequency
  task automatic wr_rates(input logic halve, input logic [15:0] br,
                          input logic [15:0] kr);
    wr16(7'h10, br);
    wr16(7'h12, halve ? {1'b0, kr[15:1]} : kr);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(negedge clock);
    regRd = 1'b1;
    regAddr = a;
    @(negedge clock);
    regRd = 1'b0;
    v = regRdata_ff;
  endtask
endmodule // rqfc_host_model

// file: tb/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb;
  reg         clock = 1'b0;
  reg         rst_b = 1'b0;
  reg  [3:0]  coarseMon = 4'h0;
  reg  [3:0]  singleMon = 4'h0;
  reg  [3:0]  lossMon = 4'h0;
  wire        regWr, regRd, statusFreeze_ff;
  wire [6:0]  regAddr;
  wire [7:0]  regWdata, regRdata_ff;
  wire [15:0] failGroup_ff, baseRate_ff, rateMult_ff;
  int         bad_count = 0, tests_run = 0, cycles = 0, n, d, i, dl;
  reg  [7:0]  rv;
  localparam [63:0] RA = 64'h0b0c0d101112130e;
  localparam [63:0] RV = 64'haa55009c400f3000;
  rqfc_ref_qualify #(.MIN_CYC(1), .D10_CYC(4), .D50_CYC(8), .D2500_CYC(16))
    dut (.clock(clock), .rst_b(rst_b), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata_ff(regRdata_ff),
    .lossOfClock(lossMon), .singleCycMon(singleMon),
    .coarseFreqMon(coarseMon),
    .failGroup_ff(failGroup_ff), .statusFreeze_ff(statusFreeze_ff),
    .baseRate_ff(baseRate_ff), .rateMult_ff(rateMult_ff));
  rqfc_host_model host (.clock(clock), .regRdata_ff(regRdata_ff),
    .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata));
  always #12.5 clock = ~clock;
  task complete_run;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wait_bit(input logic want, output int k);
    k = 0;
    while (failGroup_ff[3] !== want && k < 400) begin
      @(negedge clock);
      k++;
    end
  endtask
  // bounded run: all tests need about 820 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      complete_run;
    end
  end
  initial begin
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    for (i = 0; i < 8; i++) begin
      host.rd(RA[8*(7-i) +: 7], rv);
      `CHK(rv, RV[8*(7-i) +: 8])
    end
    $display("test reset values done");
    host.wr(7'h0e, 8'h5a);
    host.rd(7'h0e, rv);
    `CHK(rv, 8'h00)
    host.wr16(7'h10, 16'h61a8);
    host.wr16(7'h12, 16'h186a);
    `CHK(baseRate_ff, 16'h61a8)
    `CHK(rateMult_ff, 16'h186a)
    host.rd(7'h12, rv);
    `CHK(rv, 8'h18)
    host.wr_rates(1'b1, 16'h9c40, 16'h0f30);
    `CHK(baseRate_ff, 16'h9c40)
    `CHK(rateMult_ff, 16'h0798)
    $display("test rate registers done");
    host.wr(7'h0d, 8'h01);
    `CHK(statusFreeze_ff, 1'b1)
    host.wr(7'h0d, 8'h02);
    host.rd(7'h0d, rv);
    `CHK(statusFreeze_ff, 1'b1)
    `CHK(rv, 8'h02)
    host.wr(7'h0d, 8'h00);
    `CHK(statusFreeze_ff, 1'b0)
    $display("test freeze done");
    lossMon = 4'h5;
    repeat (6) @(negedge clock);
    `CHK(failGroup_ff & 16'h0f0f, 16'h0101)
    lossMon = 4'h0;
    // two sync stages plus the group register add three cycles
    for (d = 0; d < 4; d++) begin
      dl = (d == 0) ? 1 : 4 << (d - 1);
      host.wr(7'h0b, {6'h2a, d[1:0]});
      host.wr(7'h0c, {6'h15, d[1:0]});
      {singleMon[0], coarseMon[0]} = d[0] ? 2'b10 : 2'b01;
      wait_bit(1'b1, n);
      `CHK(n, dl + 3)
      repeat (30) @(negedge clock);
      {singleMon[0], coarseMon[0]} = 2'b00;
      wait_bit(1'b0, n);
      `CHK(n, (2 + 2 * d) * dl + 3)
    end
    coarseMon[0] = 1'b1;
    wait_bit(1'b1, n);
    `CHK(n, 19)
    coarseMon[0] = 1'b0;
    repeat (60) @(negedge clock);
    coarseMon[0] = 1'b1;
    repeat (2) @(negedge clock);
    coarseMon[0] = 1'b0;
    wait_bit(1'b0, n);
    `CHK(n, 131)
    repeat (150) @(negedge clock);
    $display("test soak timing done");
    complete_run;
  end
endmodule // tb
bind rqfc_ref_qualify rqfc_checker #(.NREF(NREF)) chk (.clock(clock),
  .rst_b(rst_b), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
  .regWdata(regWdata), .regRdata_ff(regRdata_ff), .lossOfClock(lossOfClock),
  .singleCycMon(singleCycMon), .coarseFreqMon(coarseFreqMon),
  .failGroup_ff(failGroup_ff), .statusFreeze_ff(statusFreeze_ff),
  .baseRate_ff(baseRate_ff), .rateMult_ff(rateMult_ff));
